// ===== frame_descriptor_dma.sv
// receive status write-back and transmit descriptor walking dma engine
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module frame_descriptor_dma #(
	parameter int MAX_PIECES = fdma_pkg::MAX_PIECES_DOC
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic [2:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             IRQ,
	output logic             M_REQ,
	output logic             M_WE,
	output logic [31:0]      M_ADDR,
	output logic [3:0]       M_BE,
	output logic [31:0]      M_WDATA,
	input  wire logic [31:0] M_RDATA,
	input  wire logic        M_ACK,
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_LAST,
	input  wire logic        RX_EXTRA_BITS,
	output logic             RX_READY,
	output logic             TX_VALID,
	output logic [7:0]       TX_DATA,
	output logic             TX_LAST,
	input  wire logic        TX_READY
);
	if (MAX_PIECES < 1 || MAX_PIECES > fdma_pkg::MAX_PIECES_DOC) begin : g_chk
		$error("MAX_PIECES must be 1 to 64");
	end

	localparam logic [6:0] LAST_IDX = 7'(MAX_PIECES - 1);

	typedef struct packed {
		fdma_pkg::eng_state_e    st;
		logic                    pend;
		logic                    mem_go;
		fdma_pkg::mem_req_s      mreq;
		logic [31:0]             tx_list;
		logic [31:0]             rx_desc;
		logic [15:0]             max_frame;
		logic                    rx_en;
		logic                    tx_act;
		logic [31:0]             desc;
		logic [31:0]             next;
		logic [31:0]             buf_addr;
		logic [13:0]             room;
		logic [15:0]             flen;
		logic                    shortfall;
		logic                    extra;
		logic                    rlast;
		logic [7:0]              rx_byte;
		logic                    rx_rdy;
		logic [6:0]              idx;
		logic [31:0]             paddr;
		logic [13:0]             pleft;
		logic                    plast;
		logic [31:0]             word;
		logic [7:0]              tx_byte;
		logic                    tx_vld;
		logic                    tx_lst;
		logic                    waitreq;
		logic [31:0]             rdata;
		logic [fdma_pkg::EV_W-1:0] irq_mask;
		logic [fdma_pkg::EV_W-1:0] ev;
		logic [fdma_pkg::EV_W-1:0] clr;
	} core_s;

	core_s s_reg;
	core_s s_next;

	logic                        mem_done;
	logic [31:0]                 mem_rdata;
	fdma_pkg::mem_req_s          m_cmd;
	logic [fdma_pkg::EV_W-1:0]   irq_status;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic fdma_pkg::mem_req_s rd_req(input logic [31:0] addr);
		fdma_pkg::mem_req_s r;
		r.we = 1'b0;
		r.addr = {addr[31:2], 2'b00};
		r.be = 4'hF;
		r.wdata = 32'h0000_0000;
		return r;
	endfunction : rd_req

	always_comb begin
		logic [31:0] piece_ofs;
		logic [31:0] cur;
		logic [31:0] rx_stat;
		logic        last_piece;
		piece_ofs = '0;
		cur = '0;
		rx_stat = '0;
		last_piece = 1'b0;
		s_next = s_reg;
		s_next.mem_go = 1'b0;
		s_next.ev = '0;
		s_next.clr = '0;
		s_next.waitreq = 1'b1;

		// register slave: waitrequest drops for one cycle, the access is taken there
		if ((AVS_READ || AVS_WRITE) && s_reg.waitreq) begin
			s_next.waitreq = 1'b0;
			case (AVS_ADDRESS)
				fdma_pkg::REG_CTRL: begin
					s_next.rdata = '0;
					s_next.rdata[fdma_pkg::CTRL_RX_EN] = s_reg.rx_en;
					s_next.rdata[fdma_pkg::CTRL_TX_ACT] = s_reg.tx_act;
				end
				fdma_pkg::REG_TX_LIST: s_next.rdata = s_reg.tx_list;
				fdma_pkg::REG_RX_DESC: s_next.rdata = s_reg.rx_desc;
				fdma_pkg::REG_MAX_FRAME: s_next.rdata = {16'h0000, s_reg.max_frame};
				fdma_pkg::REG_IRQ_STAT: s_next.rdata = {28'h0000000, irq_status};
				fdma_pkg::REG_IRQ_MASK: s_next.rdata = {28'h0000000, s_reg.irq_mask};
				fdma_pkg::REG_ENGINE: s_next.rdata = {17'h00000, s_reg.st};
				default: s_next.rdata = '0;
			endcase
		end
		if (!s_reg.waitreq && AVS_READ && AVS_ADDRESS == fdma_pkg::REG_IRQ_STAT) begin
			// clear only the bits software was shown
			s_next.clr = s_reg.rdata[fdma_pkg::EV_W-1:0];
		end
		if (!s_reg.waitreq && AVS_WRITE) begin
			cur = be_merge(32'h0000_0000, AVS_WRITEDATA, AVS_BYTEENABLE);
			case (AVS_ADDRESS)
				fdma_pkg::REG_CTRL: begin
					if (AVS_BYTEENABLE[0]) begin
						s_next.rx_en = cur[fdma_pkg::CTRL_RX_EN];
						if (cur[fdma_pkg::CTRL_TX_GO] && !s_reg.tx_act) begin
							s_next.tx_act = 1'b1;
							// kept apart from desc so a receive frame cannot lose it
							s_next.next = s_reg.tx_list & fdma_pkg::DESC_ALIGN_MASK;
						end
					end
				end
				fdma_pkg::REG_TX_LIST: s_next.tx_list = be_merge(s_reg.tx_list, AVS_WRITEDATA,
					AVS_BYTEENABLE);
				fdma_pkg::REG_RX_DESC: s_next.rx_desc = be_merge(s_reg.rx_desc, AVS_WRITEDATA,
					AVS_BYTEENABLE);
				fdma_pkg::REG_MAX_FRAME: begin
					cur = be_merge({16'h0000, s_reg.max_frame}, AVS_WRITEDATA, AVS_BYTEENABLE);
					s_next.max_frame = cur[15:0];
				end
				fdma_pkg::REG_IRQ_MASK: begin
					cur = be_merge({28'h0000000, s_reg.irq_mask}, AVS_WRITEDATA, AVS_BYTEENABLE);
					s_next.irq_mask = cur[fdma_pkg::EV_W-1:0];
				end
				default: ;
			endcase
		end

		piece_ofs = {22'h000000, s_reg.idx, 3'b000};
		last_piece = s_reg.plast || s_reg.idx == LAST_IDX;

		case (s_reg.st)
			fdma_pkg::ST_IDLE: begin
				s_next.pend = 1'b0;
				if (s_reg.rx_en && RX_VALID) begin
					s_next.st = fdma_pkg::ST_RX_CHK;
					s_next.desc = s_reg.rx_desc & fdma_pkg::DESC_ALIGN_MASK;
				end else if (s_reg.tx_act) begin
					s_next.st = fdma_pkg::ST_TX_NXT;
					s_next.desc = s_reg.next;
				end
			end
			fdma_pkg::ST_RX_CHK: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_STATUS);
				end else if (mem_done) begin
					s_next.flen = '0;
					s_next.shortfall = 1'b0;
					s_next.extra = 1'b0;
					if (mem_rdata[fdma_pkg::RXS_DONE_BIT]) begin
						// descriptor still owned by software, poll again
						s_next.st = fdma_pkg::ST_IDLE;
					end else if (mem_rdata[fdma_pkg::RXS_SINGLE_BIT]) begin
						s_next.buf_addr = s_reg.desc + fdma_pkg::OFS_PIECE_PTR;
						s_next.room = fdma_pkg::SINGLE_BUF_BYTES;
						s_next.rx_rdy = 1'b1;
						s_next.st = fdma_pkg::ST_RX_BYTE;
					end else begin
						s_next.st = fdma_pkg::ST_RX_PTR;
					end
				end
			end
			fdma_pkg::ST_RX_PTR: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_PIECE_PTR);
				end else if (mem_done) begin
					s_next.buf_addr = mem_rdata;
					s_next.st = fdma_pkg::ST_RX_LEN;
				end
			end
			fdma_pkg::ST_RX_LEN: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_PIECE_LEN);
				end else if (mem_done) begin
					s_next.room = {1'b0, mem_rdata[fdma_pkg::PIECE_LEN_W-1:0]};
					s_next.rx_rdy = 1'b1;
					s_next.st = fdma_pkg::ST_RX_BYTE;
				end
			end
			fdma_pkg::ST_RX_BYTE: begin
				if (RX_VALID && s_reg.rx_rdy) begin
					s_next.rx_rdy = 1'b0;
					s_next.rx_byte = RX_DATA;
					s_next.rlast = RX_LAST;
					s_next.flen = s_reg.flen + 16'h0001;
					if (RX_LAST) begin
						s_next.extra = RX_EXTRA_BITS;
					end
					if (s_reg.room != 14'h0000) begin
						s_next.st = fdma_pkg::ST_RX_WR;
					end else begin
						s_next.shortfall = 1'b1;
						if (RX_LAST) begin
							s_next.st = fdma_pkg::ST_RX_STAT;
						end
					end
				end else begin
					// after a dropped byte ready returns following one idle cycle
					s_next.rx_rdy = 1'b1;
				end
			end
			fdma_pkg::ST_RX_WR: begin
				if (!s_reg.pend) begin
					s_next.mreq.we = 1'b1;
					s_next.mreq.addr = {s_reg.buf_addr[31:2], 2'b00};
					s_next.mreq.be = 4'h1 << s_reg.buf_addr[1:0];
					s_next.mreq.wdata = {4{s_reg.rx_byte}};
				end else if (mem_done) begin
					s_next.buf_addr = s_reg.buf_addr + 32'h0000_0001;
					s_next.room = s_reg.room - 14'h0001;
					if (s_reg.rlast) begin
						s_next.st = fdma_pkg::ST_RX_STAT;
					end else begin
						s_next.rx_rdy = 1'b1;
						s_next.st = fdma_pkg::ST_RX_BYTE;
					end
				end
			end
			fdma_pkg::ST_RX_STAT: begin
				if (!s_reg.pend) begin
					rx_stat[fdma_pkg::RXS_DONE_BIT] = 1'b1;
					rx_stat[fdma_pkg::RXS_TOO_LONG_BIT] = s_reg.flen >= s_reg.max_frame;
					rx_stat[fdma_pkg::RXS_EXTRA_BIT] = s_reg.extra;
					rx_stat[fdma_pkg::RXS_SHORT_BIT] = s_reg.shortfall;
					rx_stat[fdma_pkg::RXS_SINGLE_BIT] = 1'b0;
					s_next.mreq.we = 1'b1;
					s_next.mreq.addr = s_reg.desc + fdma_pkg::OFS_STATUS;
					s_next.mreq.be = 4'hF;
					s_next.mreq.wdata = rx_stat;
				end else if (mem_done) begin
					s_next.st = fdma_pkg::ST_RX_NXT;
				end
			end
			fdma_pkg::ST_RX_NXT: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_NEXT);
				end else if (mem_done) begin
					s_next.ev[fdma_pkg::EV_RX_DONE] = 1'b1;
					s_next.ev[fdma_pkg::EV_RX_SHORT] = s_reg.shortfall;
					if (mem_rdata == 32'h0000_0000) begin
						s_next.rx_en = 1'b0;
					end else begin
						s_next.rx_desc = mem_rdata & fdma_pkg::DESC_ALIGN_MASK;
					end
					s_next.st = fdma_pkg::ST_IDLE;
				end
			end
			fdma_pkg::ST_TX_NXT: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_NEXT);
				end else if (mem_done) begin
					s_next.next = mem_rdata;
					s_next.idx = 7'h00;
					s_next.st = fdma_pkg::ST_TX_PPTR;
				end
			end
			fdma_pkg::ST_TX_PPTR: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_PIECE_PTR + piece_ofs);
				end else if (mem_done) begin
					s_next.paddr = mem_rdata;
					s_next.st = fdma_pkg::ST_TX_PLEN;
				end
			end
			fdma_pkg::ST_TX_PLEN: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_PIECE_LEN + piece_ofs);
				end else if (mem_done) begin
					s_next.pleft = {1'b0, mem_rdata[fdma_pkg::PIECE_LEN_W-1:0]};
					s_next.plast = mem_rdata[fdma_pkg::PIECE_LAST_BIT];
					if (mem_rdata[fdma_pkg::PIECE_LEN_W-1:0] != '0) begin
						s_next.st = fdma_pkg::ST_TX_FET;
					end else if (mem_rdata[fdma_pkg::PIECE_LAST_BIT] || s_reg.idx == LAST_IDX) begin
						s_next.st = fdma_pkg::ST_TX_CTLR;
					end else begin
						s_next.idx = s_reg.idx + 7'h01;
						s_next.st = fdma_pkg::ST_TX_PPTR;
					end
				end
			end
			fdma_pkg::ST_TX_FET: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.paddr);
				end else if (mem_done) begin
					s_next.word = mem_rdata;
					s_next.st = fdma_pkg::ST_TX_OUT;
				end
			end
			fdma_pkg::ST_TX_OUT: begin
				s_next.pend = 1'b0;
				if (!s_reg.tx_vld) begin
					s_next.tx_vld = 1'b1;
					s_next.tx_byte = s_reg.word[{s_reg.paddr[1:0], 3'b000} +: 8];
					s_next.tx_lst = s_reg.pleft == 14'h0001 && last_piece;
				end else if (TX_READY) begin
					s_next.tx_vld = 1'b0;
					s_next.tx_lst = 1'b0;
					s_next.paddr = s_reg.paddr + 32'h0000_0001;
					s_next.pleft = s_reg.pleft - 14'h0001;
					if (s_reg.pleft == 14'h0001) begin
						if (last_piece) begin
							s_next.st = fdma_pkg::ST_TX_CTLR;
						end else begin
							s_next.idx = s_reg.idx + 7'h01;
							s_next.st = fdma_pkg::ST_TX_PPTR;
						end
					end else if (s_reg.paddr[1:0] == 2'b11) begin
						s_next.st = fdma_pkg::ST_TX_FET;
					end
				end
			end
			fdma_pkg::ST_TX_CTLR: begin
				if (!s_reg.pend) begin
					s_next.mreq = rd_req(s_reg.desc + fdma_pkg::OFS_STATUS);
				end else if (mem_done) begin
					s_next.word = mem_rdata;
					s_next.st = fdma_pkg::ST_TX_CTLW;
				end
			end
			fdma_pkg::ST_TX_CTLW: begin
				if (!s_reg.pend) begin
					s_next.mreq.we = 1'b1;
					s_next.mreq.addr = s_reg.desc + fdma_pkg::OFS_STATUS;
					s_next.mreq.be = 4'hF;
					s_next.mreq.wdata = s_reg.word | (32'h0000_0001 << fdma_pkg::TXC_DONE_BIT);
				end else if (mem_done) begin
					s_next.ev[fdma_pkg::EV_TX_DESC] = 1'b1;
					if (s_reg.next == 32'h0000_0000) begin
						s_next.tx_act = 1'b0;
						s_next.ev[fdma_pkg::EV_TX_END] = 1'b1;
					end else begin
						s_next.next = s_reg.next & fdma_pkg::DESC_ALIGN_MASK;
					end
					s_next.st = fdma_pkg::ST_IDLE;
				end
			end
			default: begin
				s_next.st = fdma_pkg::ST_IDLE;
			end
		endcase

		// every memory state issues its access once, on entry
		if (!s_reg.pend && s_reg.st != fdma_pkg::ST_IDLE && s_reg.st != fdma_pkg::ST_RX_BYTE
			&& s_reg.st != fdma_pkg::ST_TX_OUT) begin
			s_next.mem_go = 1'b1;
			s_next.pend = 1'b1;
		end
		if (mem_done) begin
			s_next.pend = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			s_reg <= '0;
			s_reg.st <= fdma_pkg::ST_IDLE;
			s_reg.max_frame <= fdma_pkg::MAX_FRAME_RST;
			s_reg.waitreq <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	mem_master_port u_mem (
		.clk    (CLK_SYS),
		.rst_n  (RST_N),
		.go     (s_reg.mem_go),
		.req_in (s_reg.mreq),
		.done   (mem_done),
		.rdata  (mem_rdata),
		.m_req  (M_REQ),
		.m_cmd  (m_cmd),
		.m_rdata(M_RDATA),
		.m_ack  (M_ACK)
	);

	sticky_irq #(
		.W(fdma_pkg::EV_W)
	) u_irq (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.set   (s_reg.ev),
		.clr   (s_reg.clr),
		.mask  (s_reg.irq_mask),
		.status(irq_status),
		.irq   (IRQ)
	);

	assign M_WE            = m_cmd.we;
	assign M_ADDR          = m_cmd.addr;
	assign M_BE            = m_cmd.be;
	assign M_WDATA         = m_cmd.wdata;
	assign AVS_READDATA    = s_reg.rdata;
	assign AVS_WAITREQUEST = s_reg.waitreq;
	assign RX_READY        = s_reg.rx_rdy;
	assign TX_VALID        = s_reg.tx_vld;
	assign TX_DATA         = s_reg.tx_byte;
	assign TX_LAST         = s_reg.tx_lst;
endmodule : frame_descriptor_dma

// ===== fdma_pkg.sv
// shared constants, types and behaviour list of the frame descriptor dma engine
// Behaviour
// - flag frames whose length reaches the maximum limit
// - report extra trailing bits without marking error
// - fill short buffers, drop remainder, flag shortfall
// - single mode uses one 1528-byte buffer at +0x08
// - sample single mode alongside the done flag check
// - status write-back leaves single mode undefined
// - piece pointer n sits at 0x08 plus 8n
// - transmit pieces may start on any byte
// - piece size n at 0x0C plus 8n, 13 bits
// - bit 31 marks last piece, then next descriptor
// - next pointer at 0x00, zero ends the list
// - set receive done bit 15 after whole frame
// - set transmit done bit 16 after all pieces
package fdma_pkg;

	// register word indices, byte address is four times the index
	localparam logic [2:0] REG_CTRL      = 3'h0;
	localparam logic [2:0] REG_TX_LIST   = 3'h1;
	localparam logic [2:0] REG_RX_DESC   = 3'h2;
	localparam logic [2:0] REG_MAX_FRAME = 3'h3;
	localparam logic [2:0] REG_IRQ_STAT  = 3'h4;
	localparam logic [2:0] REG_IRQ_MASK  = 3'h5;
	localparam logic [2:0] REG_ENGINE    = 3'h6;

	localparam int CTRL_TX_GO  = 0;
	localparam int CTRL_RX_EN  = 1;
	localparam int CTRL_TX_ACT = 2;

	localparam logic [15:0] MAX_FRAME_RST = 16'h05EE;

	// interrupt event bits
	localparam int EV_W         = 4;
	localparam int EV_RX_DONE   = 0;
	localparam int EV_TX_DESC   = 1;
	localparam int EV_TX_END    = 2;
	localparam int EV_RX_SHORT  = 3;

	// descriptor layout
	localparam logic [31:0] OFS_NEXT      = 32'h0000_0000;
	localparam logic [31:0] OFS_STATUS    = 32'h0000_0004;
	localparam logic [31:0] OFS_PIECE_PTR = 32'h0000_0008;
	localparam logic [31:0] OFS_PIECE_LEN = 32'h0000_000C;
	localparam logic [31:0] DESC_ALIGN_MASK = 32'hFFFF_FFF8;
	localparam logic [13:0] SINGLE_BUF_BYTES = 14'h05F8;
	localparam int MAX_PIECES_DOC = 64;
	localparam int PIECE_LEN_W    = 13;
	localparam int PIECE_LAST_BIT = 31;

	localparam int RXS_DONE_BIT     = 15;
	localparam int RXS_TOO_LONG_BIT = 20;
	localparam int RXS_EXTRA_BIT    = 23;
	localparam int RXS_SHORT_BIT    = 24;
	localparam int RXS_SINGLE_BIT   = 28;
	localparam int TXC_DONE_BIT     = 16;

	typedef enum logic [14:0] {
		ST_IDLE    = 15'h0001,
		ST_RX_CHK  = 15'h0002,
		ST_RX_PTR  = 15'h0004,
		ST_RX_LEN  = 15'h0008,
		ST_RX_BYTE = 15'h0010,
		ST_RX_WR   = 15'h0020,
		ST_RX_STAT = 15'h0040,
		ST_RX_NXT  = 15'h0080,
		ST_TX_NXT  = 15'h0100,
		ST_TX_PPTR = 15'h0200,
		ST_TX_PLEN = 15'h0400,
		ST_TX_FET  = 15'h0800,
		ST_TX_OUT  = 15'h1000,
		ST_TX_CTLR = 15'h2000,
		ST_TX_CTLW = 15'h4000
	} eng_state_e;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} mem_req_s;

endpackage : fdma_pkg

// ===== mem_master_port.sv
// single-beat host memory master port that holds a request until acknowledged
`timescale 1ns/1ps
module mem_master_port (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               go,
	input  wire fdma_pkg::mem_req_s req_in,
	output logic                    done,
	output logic [31:0]             rdata,
	output logic                    m_req,
	output fdma_pkg::mem_req_s      m_cmd,
	input  wire logic [31:0]        m_rdata,
	input  wire logic               m_ack
);
	typedef struct packed {
		logic               req;
		fdma_pkg::mem_req_s cmd;
		logic               done;
		logic [31:0]        rdata;
	} port_s;

	port_s s_reg;
	port_s s_next;

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (s_reg.req) begin
			if (m_ack) begin
				s_next.req = 1'b0;
				s_next.done = 1'b1;
				s_next.rdata = m_rdata;
			end
		end else if (go) begin
			s_next.req = 1'b1;
			s_next.cmd = req_in;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign done  = s_reg.done;
	assign rdata = s_reg.rdata;
	assign m_req = s_reg.req;
	assign m_cmd = s_reg.cmd;
endmodule : mem_master_port

// ===== sticky_irq.sv
// sticky event status with read clear, mask and level interrupt
`timescale 1ns/1ps
module sticky_irq #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	input  wire logic [W-1:0] mask,
	output logic [W-1:0]      status,
	output logic              irq
);
	typedef struct packed {
		logic [W-1:0] status;
		logic         irq;
	} irq_s;

	irq_s s_reg;
	irq_s s_next;

	always_comb begin
		s_next = s_reg;
		// a new event wins over a clear in the same cycle
		s_next.status = (s_reg.status & ~clr) | set;
		s_next.irq = |(s_next.status & mask);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign status = s_reg.status;
	assign irq    = s_reg.irq;
endmodule : sticky_irq

// ===== fdma_checker.sv
// port level assertions for the frame descriptor dma engine
`timescale 1ns/1ps
module fdma_checker (
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        M_REQ,
	input wire logic        M_WE,
	input wire logic [31:0] M_ADDR,
	input wire logic [3:0]  M_BE,
	input wire logic [31:0] M_WDATA,
	input wire logic        M_ACK,
	input wire logic        RX_VALID,
	input wire logic        RX_READY,
	input wire logic        TX_VALID,
	input wire logic [7:0]  TX_DATA,
	input wire logic        TX_READY
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence mem_end;
		M_REQ && M_ACK;
	endsequence
	sequence mem_rest;
		!M_REQ [*2];
	endsequence
	bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
		!AVS_WAITREQUEST) else $error("bus access not answered");
	bus_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	mem_hold_a: assert property (M_REQ && !M_ACK |=> M_REQ && $stable(M_ADDR) &&
		$stable(M_WE) && $stable(M_WDATA)) else $error("memory request changed");
	mem_gap_a: assert property (mem_end |=> mem_rest)
		else $error("memory accesses too close");
	word_addr_a: assert property (M_REQ |-> M_ADDR[1:0] == 2'h0)
		else $error("memory address not word aligned");
	byte_lane_a: assert property (M_REQ && M_WE && M_BE != 4'hF |->
		$onehot(M_BE) && M_WDATA == {4{M_WDATA[7:0]}}) else $error("bad byte write");
	done_flag_a: assert property (M_REQ && M_WE && M_BE == 4'hF |->
		M_WDATA[15] || M_WDATA[16]) else $error("write back without done flag");
	rx_gap_a: assert property (RX_VALID && RX_READY |=> !RX_READY)
		else $error("receive ready not dropped");
	tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("transmit byte changed while stalled");
	tx_gap_a: assert property (TX_VALID && TX_READY |=> !TX_VALID)
		else $error("transmit valid not dropped");
endmodule : fdma_checker

bind frame_descriptor_dma fdma_checker i_fdma_checker (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .M_REQ(M_REQ), .M_WE(M_WE), .M_ADDR(M_ADDR),
	.M_BE(M_BE), .M_WDATA(M_WDATA), .M_ACK(M_ACK), .RX_VALID(RX_VALID),
	.RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY)
);

// ===== host_mem_model.sv
// host memory answering the engine after an adjustable delay
`timescale 1ns/1ps
module host_mem_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        m_req,
	input  wire logic        m_we,
	input  wire logic [31:0] m_addr,
	input  wire logic [3:0]  m_be,
	input  wire logic [31:0] m_wdata,
	input  wire logic [3:0]  lat,
	output logic [31:0]      m_rdata,
	output logic             m_ack
);
	logic [31:0] mem [0:1023];
	logic [3:0]  cnt;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m_ack <= 1'b0;
			m_rdata <= 32'h0;
			cnt <= 4'h0;
		end else if (m_req && !m_ack && cnt >= lat) begin
			m_ack <= 1'b1;
			m_rdata <= mem[m_addr[11:2]];
			cnt <= 4'h0;
			for (int b = 0; b < 4; b++)
				if (m_we && m_be[b]) mem[m_addr[11:2]][8*b+:8] <= m_wdata[8*b+:8];
		end else begin
			// data keeps moving so a stale word never passes for an answer
			m_ack <= 1'b0;
			m_rdata <= ~m_rdata;
			if (m_req && !m_ack) cnt <= cnt + 4'h1;
		end
	end
endmodule : host_mem_model

// ===== tb.sv
// self-checking bench of the frame descriptor dma engine
`timescale 1ns/1ps
module tb;
	logic        clk, rst_n, rd, wr, irq, wait_req, m_req, m_we, m_ack;
	logic        rx_valid, rx_last, rx_extra, rx_ready, tx_valid, tx_last, tx_ready;
	logic [2:0]  adr;
	logic [3:0]  m_be, lat;
	logic [7:0]  rx_data, tx_data;
	logic [31:0] wdata, rdata, m_addr, m_wdata, m_rdata, got;
	logic [8:0]  txq[$];
	int          error_cnt, checks_done;
	localparam logic [31:0] DESC [44] = '{
		32'h010, 32'h0, 32'h014, 32'h1000_0000,
		32'h800, 32'h0, 32'h804, 32'h0, 32'h808, 32'h901, 32'h80C, 32'h3,
		32'hA00, 32'hB00, 32'hA04, 32'h0, 32'hA08, 32'hC03, 32'hA0C, 32'h3,
		32'hA10, 32'hC10, 32'hA14, 32'h8000_0002, 32'hB00, 32'hB45, 32'hB04, 32'h0,
		32'hB08, 32'hC21, 32'hB0C, 32'h8000_0001, 32'hB40, 32'h0, 32'hB48, 32'hC30,
		32'hB4C, 32'h1, 32'hB50, 32'hC38, 32'hB44, 32'h0, 32'hB54, 32'h1};
	localparam logic [31:0] TXA [8] = '{32'hC03, 32'hC04, 32'hC05, 32'hC10, 32'hC11,
		32'hC21, 32'hC30, 32'hC38};

	frame_descriptor_dma #(.MAX_PIECES(2)) i_frame_descriptor_dma (
		.CLK_SYS(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .IRQ(irq), .M_REQ(m_req), .M_WE(m_we), .M_ADDR(m_addr),
		.M_BE(m_be), .M_WDATA(m_wdata), .M_RDATA(m_rdata), .M_ACK(m_ack),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_EXTRA_BITS(rx_extra),
		.RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
		.TX_READY(tx_ready));
	host_mem_model i_host_mem_model (.clk(clk), .rst_n(rst_n), .m_req(m_req), .m_we(m_we),
		.m_addr(m_addr), .m_be(m_be), .m_wdata(m_wdata), .lat(lat), .m_rdata(m_rdata),
		.m_ack(m_ack));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// far side stalls every other cycle
	always @(posedge clk) begin
		if (tx_valid && tx_ready) txq.push_back({tx_last, tx_data});
		tx_ready <= !tx_ready;
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		conclude();
	end

	function automatic logic [7:0] pat(input logic [31:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction
	function automatic logic [31:0] byt(input logic [31:0] a);
		return {24'h0, 8'(i_host_mem_model.mem[a[11:2]] >> (8 * a[1:0]))};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task acc(input logic w, input logic [2:0] a, input logic [31:0] d);
		adr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wait_req !== 1'b0);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task rx_send(input int n, input logic x);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data <= 8'(i + 16);
			rx_last <= (i == n - 1);
			rx_extra <= x;
			do @(posedge clk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
	endtask
	task quiet;
		do acc(1'b0, fdma_pkg::REG_CTRL, 32'h0); while (got[2:1] !== 2'h0);
	endtask
	task irq_is(input logic b);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, {31'h0, b});
	endtask
	task conclude;
		if (error_cnt == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		{rd, wr, rx_valid, rx_last, rx_extra, tx_ready} = 6'h0;
		adr = 3'h0;
		wdata = 32'h0;
		rx_data = 8'h0;
		lat = 4'h0;
		rst_n = 1'b0;
		for (int i = 0; i < 4096; i++) i_host_mem_model.mem[i / 4][8 * (i % 4) +: 8] = pat(32'(i));
		for (int i = 0; i < 44; i += 2) i_host_mem_model.mem[DESC[i][11:2]] = DESC[i + 1];
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		acc(1'b0, fdma_pkg::REG_MAX_FRAME, 32'h0);
		chk(got, 32'h0000_05EE);
		acc(1'b1, 3'h7, 32'hFFFF_FFFF);
		acc(1'b0, 3'h7, 32'h0);
		chk(got, 32'h0);
		acc(1'b1, fdma_pkg::REG_IRQ_MASK, 32'h1);
		acc(1'b1, fdma_pkg::REG_MAX_FRAME, 32'h0000_05FA);
		acc(1'b1, fdma_pkg::REG_RX_DESC, 32'h10);
		acc(1'b1, fdma_pkg::REG_CTRL, 32'h2);
		rx_send(1530, 1'b1);
		quiet();
		chk(byt(32'h14) | byt(32'h15) << 8 | byt(32'h16) << 16 | byt(32'h17) << 24,
			32'h0190_8000);
		for (int i = 0; i < 1528; i++) chk(byt(32'h18 + i), {24'h0, 8'(i + 16)});
		chk(byt(32'h610), {24'h0, pat(32'h610)});
		irq_is(1'b1);
		acc(1'b0, fdma_pkg::REG_IRQ_STAT, 32'h0);
		chk(got, 32'h9);
		irq_is(1'b0);
		acc(1'b1, fdma_pkg::REG_RX_DESC, 32'h800);
		acc(1'b1, fdma_pkg::REG_CTRL, 32'h2);
		rx_send(5, 1'b0);
		quiet();
		chk(i_host_mem_model.mem[32'h804 >> 2], 32'h0100_8000);
		for (int i = 0; i < 5; i++)
			chk(byt(32'h900 + i), (i == 0 || i == 4) ? {24'h0, pat(32'h900 + i)} :
				{24'h0, 8'(i + 15)});
		acc(1'b0, fdma_pkg::REG_IRQ_STAT, 32'h0);
		chk(got, 32'h9);
		lat <= 4'h2;
		acc(1'b1, fdma_pkg::REG_TX_LIST, 32'hA00);
		acc(1'b1, fdma_pkg::REG_CTRL, 32'h1);
		quiet();
		chk(32'(txq.size()), 32'h8);
		for (int i = 0; i < 8; i++)
			chk({23'h0, txq[i]}, {23'h0, i == 4 || i == 5 || i == 7, pat(TXA[i])});
		acc(1'b0, fdma_pkg::REG_ENGINE, 32'h0);
		chk(got, 32'h1);
		chk(i_host_mem_model.mem[32'hA04 >> 2], 32'h0001_0000);
		chk(i_host_mem_model.mem[32'hB04 >> 2], 32'h0001_0000);
		chk(i_host_mem_model.mem[32'hB44 >> 2], 32'h0001_0000);
		irq_is(1'b0);
		acc(1'b1, fdma_pkg::REG_IRQ_MASK, 32'h4);
		irq_is(1'b1);
		acc(1'b0, fdma_pkg::REG_IRQ_STAT, 32'h0);
		chk(got, 32'h6);
		irq_is(1'b0);
		conclude();
	end
endmodule : tb
